// File: core/ddc_cmd_decoder.sv
// serial word capture, word fifo and latch update logic of the dual converter
// Functional notes
// RL1: control word uses only D1..D0 as reference field, D11..D2 ignored.
// RL2: reference 00/11 external, 01 internal 1.024 V, 10 internal 2.048 V.
// RL3: host selects external reference whenever one is applied externally.
// RL4: DAC A word updates output A after its last bit D0.
// RL5: DAC A word after buffer write updates both outputs together.
// RL6: control settings persist across later data words.
// RL7: any word with D13 set enters power-down.
// RL8: D14 of every word selects fast (1) or slow (0) settling.
// RL9: select 01 loads buffer only, outputs unchanged.
// RL10: select 00 loads buffer and output B together.
// RL11: MSB first, one bit per falling serial clock edge after select falls.
// RL12: transfer after 16 bits, or earlier when select rises.
// RL13: select 10 writes A and copies buffer to B; 11 writes control.
// RL14: converter words use D11..D2 as code, D1..D0 ignored.
// RL15: reset clears buffer, outputs, speed, power-down and reference field.
// RL16: a later word with D13 clear leaves power-down.
`timescale 1ns/1ps
`default_nettype none

module ddc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    wrPtr_nxt;
  logic [AW-1:0]    rdPtr_r;
  logic [AW-1:0]    rdPtr_nxt;
  logic [AW:0]      fill_r;
  logic [AW:0]      fill_nxt;
  logic             push;
  logic             pop;

  always_comb
  begin
    inReady = (fill_r != FULL);
    outValid = (fill_r != '0);
    outData = mem[rdPtr_r];
    push = inValid && inReady;
    pop = outValid && outReady;
    wrPtr_nxt = push ? ((wrPtr_r == LAST) ? '0 : wrPtr_r + 1'b1) : wrPtr_r;
    rdPtr_nxt = pop ? ((rdPtr_r == LAST) ? '0 : rdPtr_r + 1'b1) : rdPtr_r;
    fill_nxt = fill_r;
    if (push && !pop)
    begin
      fill_nxt = fill_r + 1'b1;
    end
    else if (pop && !push)
    begin
      fill_nxt = fill_r - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      fill_r <= '0;
    end
    else
    begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      fill_r <= fill_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wrPtr_r] <= inData;
    end
  end
endmodule : ddc_fifo

module ddc_cmd_decoder #(
  parameter int FIFO_DEPTH = ddc_pkg::FIFO_DEPTH
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic        din,
  output logic       [9:0] outputFirst,
  output logic       [9:0] outputSecond,
  output logic       [9:0] bufferCode,
  output logic             speedSelect,
  output logic             powerDownBit,
  output logic             refselHi,
  output logic             refselLo,
  output logic       [1:0] refSource
);
  // ---- link side, clocked by the host serial clock
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic [4:0]  bitCnt_r;
  logic [4:0]  bitCnt_nxt;
  logic        inFrame_r;
  logic        sent_r;
  logic        sent_nxt;
  logic        postTgl_r;
  logic        postTgl_nxt;
  logic        frameClr;
  logic        wordDone;

  assign frameClr = csN | ~arst_n;
  assign wordDone = inFrame_r && (bitCnt_r == ddc_pkg::CNT_FULL);

  always_comb
  begin
    shift_nxt = shift_r;
    bitCnt_nxt = bitCnt_r;
    if (!csN && !inFrame_r)
    begin
      shift_nxt = {15'h0000, din}; // RL11
      bitCnt_nxt = 5'h01;
    end
    else if (!csN && bitCnt_r != ddc_pkg::CNT_FULL)
    begin
      shift_nxt = {shift_r[14:0], din}; // RL11
      bitCnt_nxt = bitCnt_r + 5'h01;
    end
    sent_nxt = sent_r | wordDone;
    postTgl_nxt = postTgl_r ^ (wordDone && !sent_r); // RL12
  end

  always_ff @(negedge sclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shift_r <= ddc_pkg::RST_WORD;
      bitCnt_r <= '0;
    end
    else
    begin
      shift_r <= shift_nxt;
      bitCnt_r <= bitCnt_nxt;
    end
  end

  // frame flags end with the select line itself, the clock may stop
  always_ff @(negedge sclk or posedge frameClr)
  begin
    if (frameClr)
    begin
      inFrame_r <= 1'b0;
    end
    else
    begin
      inFrame_r <= 1'b1;
    end
  end

  always_ff @(posedge sclk or posedge frameClr)
  begin
    if (frameClr)
    begin
      sent_r <= 1'b0;
    end
    else
    begin
      sent_r <= sent_nxt;
    end
  end

  // word posted on the rising edge after the last bit
  always_ff @(posedge sclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      postTgl_r <= 1'b0;
    end
    else
    begin
      postTgl_r <= postTgl_nxt;
    end
  end

  // ---- core side
  logic [1:0]  rstSync_r;
  logic        rstN;
  logic [1:0]  csSync_r;
  logic        csSeen_r;
  logic [1:0]  tglSync_r;
  logic        tglSeen_r;
  logic        wordEvt;
  logic        pendValid_r;
  logic        pendValid_nxt;
  logic [15:0] pendWord_r;
  logic [15:0] pendWord_nxt;
  logic        fifoInReady;
  logic        fifoOutValid;
  logic [15:0] fifoOutData;
  logic        fifoOutReady;

  assign rstN = rstSync_r[1];

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstSync_r <= 2'h0;
    end
    else
    begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      csSync_r <= 2'h3;
      csSeen_r <= 1'b1;
      tglSync_r <= 2'h0;
      tglSeen_r <= 1'b0;
    end
    else
    begin
      csSync_r <= {csSync_r[0], csN};
      csSeen_r <= csSync_r[1];
      tglSync_r <= {tglSync_r[0], postTgl_r};
      tglSeen_r <= tglSync_r[1];
    end
  end

  // short frame: link registers are still once select is high
  always_comb
  begin
    wordEvt = (tglSync_r[1] != tglSeen_r) ||
              (csSync_r[1] && !csSeen_r && bitCnt_r != 5'h00 &&
               bitCnt_r != ddc_pkg::CNT_FULL); // RL12
    pendValid_nxt = pendValid_r && !fifoInReady;
    pendWord_nxt = pendWord_r;
    if (wordEvt)
    begin
      pendValid_nxt = 1'b1;
      pendWord_nxt = shift_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      pendValid_r <= 1'b0;
      pendWord_r <= ddc_pkg::RST_WORD;
    end
    else
    begin
      pendValid_r <= pendValid_nxt;
      pendWord_r <= pendWord_nxt;
    end
  end

  ddc_fifo #(
    .WIDTH (ddc_pkg::WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) wordFifo (
    .clk      (ref_clk),
    .rstN     (rstN),
    .inValid  (pendValid_r),
    .inData   (pendWord_r),
    .inReady  (fifoInReady),
    .outValid (fifoOutValid),
    .outData  (fifoOutData),
    .outReady (fifoOutReady)
  );

  // ---- decode and latch update
  ddc_pkg::ddc_state_t state_r;
  ddc_pkg::ddc_state_t state_nxt;
  logic [15:0] word_r;
  logic [15:0] word_nxt;
  logic [9:0]  dacA_r;
  logic [9:0]  dacA_nxt;
  logic [9:0]  dacB_r;
  logic [9:0]  dacB_nxt;
  logic [9:0]  buf_r;
  logic [9:0]  buf_nxt;
  logic        speed_r;
  logic        speed_nxt;
  logic        pwr_r;
  logic        pwr_nxt;
  logic [1:0]  refsel_r;
  logic [1:0]  refsel_nxt;
  logic [1:0]  refSrc_r;
  logic [1:0]  refSrc_nxt;
  logic [1:0]  sel;
  logic [9:0]  newCode;
  logic        applying;

  assign sel = {word_r[ddc_pkg::BIT_SEL_HI], word_r[ddc_pkg::BIT_SEL_LO]};
  assign newCode = word_r[ddc_pkg::CODE_MSB:ddc_pkg::CODE_LSB]; // RL14
  assign applying = (state_r == ddc_pkg::ST_APPLY);
  assign fifoOutReady = (state_r == ddc_pkg::ST_IDLE);

  always_comb
  begin
    state_nxt = state_r;
    word_nxt = word_r;
    dacA_nxt = dacA_r;
    dacB_nxt = dacB_r;
    buf_nxt = buf_r;
    speed_nxt = speed_r;
    pwr_nxt = pwr_r;
    refsel_nxt = refsel_r; // RL6
    unique case (state_r)
      ddc_pkg::ST_IDLE:
      begin
        if (fifoOutValid)
        begin
          word_nxt = fifoOutData;
          state_nxt = ddc_pkg::ST_APPLY;
        end
      end
      ddc_pkg::ST_APPLY:
      begin
        state_nxt = ddc_pkg::ST_IDLE;
        speed_nxt = word_r[ddc_pkg::BIT_SPEED]; // RL8
        pwr_nxt = word_r[ddc_pkg::BIT_PWR]; // RL7 RL16
        unique case (sel)
          ddc_pkg::SEL_B_BUF:
          begin
            buf_nxt = newCode; // RL10
            dacB_nxt = newCode; // RL10
          end
          ddc_pkg::SEL_BUF:
          begin
            buf_nxt = newCode; // RL9
          end
          ddc_pkg::SEL_A_XFER:
          begin
            dacA_nxt = newCode; // RL4 RL13
            dacB_nxt = buf_r; // RL5 RL13
          end
          ddc_pkg::SEL_CTRL:
          begin
            refsel_nxt = word_r[ddc_pkg::REF_HI:ddc_pkg::REF_LO]; // RL1 RL13
          end
        endcase
      end
    endcase
    unique case (refsel_nxt)
      ddc_pkg::REF_INT_1V024: refSrc_nxt = ddc_pkg::SRC_INT_1V024; // RL2
      ddc_pkg::REF_INT_2V048: refSrc_nxt = ddc_pkg::SRC_INT_2V048; // RL2
      default: refSrc_nxt = ddc_pkg::SRC_EXTERNAL; // RL2 RL3
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_r <= ddc_pkg::ST_IDLE;
      word_r <= ddc_pkg::RST_WORD;
      dacA_r <= ddc_pkg::RST_CODE; // RL15
      dacB_r <= ddc_pkg::RST_CODE; // RL15
      buf_r <= ddc_pkg::RST_CODE; // RL15
      speed_r <= 1'b0; // RL15
      pwr_r <= 1'b0; // RL15
      refsel_r <= ddc_pkg::RST_REFSEL; // RL15
      refSrc_r <= ddc_pkg::SRC_EXTERNAL;
    end
    else
    begin
      state_r <= state_nxt;
      word_r <= word_nxt;
      dacA_r <= dacA_nxt;
      dacB_r <= dacB_nxt;
      buf_r <= buf_nxt;
      speed_r <= speed_nxt;
      pwr_r <= pwr_nxt;
      refsel_r <= refsel_nxt;
      refSrc_r <= refSrc_nxt;
    end
  end

  assign outputFirst = dacA_r;
  assign outputSecond = dacB_r;
  assign bufferCode = buf_r;
  assign speedSelect = speed_r;
  assign powerDownBit = pwr_r;
  assign refselHi = refsel_r[1];
  assign refselLo = refsel_r[0];
  assign refSource = refSrc_r;

  // ---- checks
  sequence sApply(logic [1:0] code);
    applying && sel == code;
  endsequence

  AST_CTRL_FIELD: assert property (@(posedge ref_clk) disable iff (!rstN) // RL1
    sApply(ddc_pkg::SEL_CTRL) |=> refsel_r == $past(word_r[1:0]) && $stable(dacA_r)
      && $stable(dacB_r) && $stable(buf_r))
    else $error("control word did not load only the reference field");
  AST_REF_DECODE: assert property (@(posedge ref_clk) disable iff (!rstN) // RL2
    (refsel_r == 2'h1) == (refSrc_r == 2'h1) && (refsel_r == 2'h2) == (refSrc_r == 2'h2))
    else $error("reference source does not match reference field");
  AST_A_UPDATE: assert property (@(posedge ref_clk) disable iff (!rstN) // RL4
    sApply(ddc_pkg::SEL_A_XFER) |=> outputFirst == $past(newCode))
    else $error("output A not updated by DAC A word");
  AST_BOTH_UPDATE: assert property (@(posedge ref_clk) disable iff (!rstN) // RL5
    sApply(ddc_pkg::SEL_A_XFER) |=> outputSecond == $past(buf_r) && $stable(buf_r))
    else $error("output B not loaded from buffer with DAC A word");
  AST_CTRL_HOLD: assert property (@(posedge ref_clk) disable iff (!rstN) // RL6
    applying && sel != ddc_pkg::SEL_CTRL |=> $stable(refsel_r))
    else $error("reference field changed on a data word");
  AST_PWR_ON: assert property (@(posedge ref_clk) disable iff (!rstN) // RL7
    applying && word_r[13] |=> powerDownBit ##1 powerDownBit || applying)
    else $error("power-down not entered");
  AST_SPEED: assert property (@(posedge ref_clk) disable iff (!rstN) // RL8
    applying |=> speedSelect == $past(word_r[14]))
    else $error("speed bit not taken from word");
  AST_BUF_ONLY: assert property (@(posedge ref_clk) disable iff (!rstN) // RL9
    sApply(ddc_pkg::SEL_BUF) |=> $stable(dacA_r) && $stable(dacB_r) && buf_r == $past(newCode))
    else $error("buffer-only word touched outputs");
  AST_B_AND_BUF: assert property (@(posedge ref_clk) disable iff (!rstN) // RL10
    sApply(ddc_pkg::SEL_B_BUF) |=> outputSecond == buf_r && buf_r == $past(newCode))
    else $error("buffer and output B not loaded together");
  AST_WAKE: assert property (@(posedge ref_clk) disable iff (!rstN) // RL16
    applying && !word_r[13] |=> !powerDownBit)
    else $error("power-down not left");
  // select rises right after the post edge, so the toggle is checked at the next frame's edge
  AST_POST_ONCE: assert property (@(posedge sclk) disable iff (!arst_n) // RL12
    wordDone && !sent_r |=> postTgl_r != $past(postTgl_r))
    else $error("complete word not posted");
endmodule : ddc_cmd_decoder

`default_nettype wire

// File: core/ddc_pkg.sv
// shared constants and types of the dual converter serial command decoder
package ddc_pkg;
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 10;
  localparam int FIFO_DEPTH = 4;
  // field positions inside a received word
  localparam int BIT_SEL_HI = 15;
  localparam int BIT_SPEED = 14;
  localparam int BIT_PWR = 13;
  localparam int BIT_SEL_LO = 12;
  localparam int CODE_MSB = 11;
  localparam int CODE_LSB = 2;
  localparam int REF_HI = 1;
  localparam int REF_LO = 0;
  // bit counter value that marks a complete word
  localparam logic [4:0] CNT_FULL = 5'h10;
  // target select codes {target_sel_hi, target_sel_lo}
  localparam logic [1:0] SEL_B_BUF = 2'h0;
  localparam logic [1:0] SEL_BUF = 2'h1;
  localparam logic [1:0] SEL_A_XFER = 2'h2;
  localparam logic [1:0] SEL_CTRL = 2'h3;
  // reference field codes
  localparam logic [1:0] REF_EXT_LO = 2'h0;
  localparam logic [1:0] REF_INT_1V024 = 2'h1;
  localparam logic [1:0] REF_INT_2V048 = 2'h2;
  localparam logic [1:0] REF_EXT_HI = 2'h3;
  // reset values
  localparam logic [9:0] RST_CODE = 10'h000;
  localparam logic [1:0] RST_REFSEL = 2'h0;
  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef enum logic [1:0] {
    SRC_EXTERNAL = 2'h0,
    SRC_INT_1V024 = 2'h1,
    SRC_INT_2V048 = 2'h2
  } ddc_ref_src_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_APPLY = 1'b1
  } ddc_state_t;
endpackage : ddc_pkg

// File: tb/ddc_host_model.sv
// host serial port model driving select, serial clock and data
`timescale 1ns/1ps
`default_nettype none

module ddc_host_model #(
  parameter real HALF_NS = 6.0
) (
  output logic sclk,
  output logic csN,
  output logic din
);
  initial
  begin
    sclk = 1'b1;
    csN  = 1'b1;
    din  = 1'b0;
  end

  // one frame of nbits; clock idles high and only toggles inside a frame
  task automatic send_word(input logic [15:0] word, input int nbits);
    int i;
    begin
      csN = 1'b0;
      #(2.0 * HALF_NS);
      for (i = nbits - 1; i >= 0; i--)
      begin
        din = word[i];
        #(HALF_NS);
        sclk = 1'b0;
        #(HALF_NS);
        sclk = 1'b1;
      end
      #(HALF_NS);
      csN = 1'b1;
      // released line shows the inverse of the last bit
      din = ~din;
      // select stays high long enough for the core to see it
      #(16.0 * HALF_NS);
    end
  endtask : send_word
endmodule : ddc_host_model

`default_nettype wire

// File: tb/dual_dac_serial_command_decoder_tb.sv
// self-checking bench of the dual converter serial command decoder
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, act) \
  begin \
    comparisons++; \
    if ((act) !== (exp)) \
    begin \
      errors++; \
      $display("unexpected %s expected %h seen %h", nm, exp, act); \
    end \
  end

module dual_dac_serial_command_decoder_tb;
  logic       ref_clk;
  logic       arst_n;
  logic       sclk;
  logic       csN;
  logic       din;
  logic [9:0] outputFirst;
  logic [9:0] outputSecond;
  logic [9:0] bufferCode;
  logic       speedSelect;
  logic       powerDownBit;
  logic       refselHi;
  logic       refselLo;
  logic [1:0] refSource;
  int         errors;
  int         comparisons;
  int         cycles;
  int         i;
  logic [9:0] eA;
  logic [9:0] eB;
  logic [9:0] eBuf;
  logic       eSpd;
  logic       ePwr;
  logic [1:0] eRef;
  logic [1:0] eSrc;

  ddc_host_model host_u (
    .sclk (sclk),
    .csN  (csN),
    .din  (din)
  );

  ddc_cmd_decoder #(
    .FIFO_DEPTH (ddc_pkg::FIFO_DEPTH)
  ) dut_u (
    .ref_clk      (ref_clk),
    .arst_n       (arst_n),
    .sclk         (sclk),
    .csN          (csN),
    .din          (din),
    .outputFirst  (outputFirst),
    .outputSecond (outputSecond),
    .bufferCode   (bufferCode),
    .speedSelect  (speedSelect),
    .powerDownBit (powerDownBit),
    .refselHi     (refselHi),
    .refselLo     (refselLo),
    .refSource    (refSource)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      errors++;
      conclude();
    end
  end

  task automatic check();
    eSrc = (eRef == ddc_pkg::REF_INT_1V024 || eRef == ddc_pkg::REF_INT_2V048) ? eRef : 2'h0;
    `CHK("outputFirst", eA, outputFirst)
    `CHK("outputSecond", eB, outputSecond)
    `CHK("bufferCode", eBuf, bufferCode)
    `CHK("speedSelect", eSpd, speedSelect)
    `CHK("powerDownBit", ePwr, powerDownBit)
    `CHK("refselHi", eRef[1], refselHi)
    `CHK("refselLo", eRef[0], refselLo)
    `CHK("refSource", eSrc, refSource)
  endtask : check

  // send one frame, track the expected latches, optionally settle and compare
  task automatic xfer(input logic [15:0] w, input int nbits, input logic settle);
    logic [15:0] v;
    logic [9:0]  code;
    begin
      v = (nbits >= 16) ? w : (w & ((16'h1 << nbits) - 16'h1));
      code = v[ddc_pkg::CODE_MSB:ddc_pkg::CODE_LSB];
      eSpd = v[ddc_pkg::BIT_SPEED];
      ePwr = v[ddc_pkg::BIT_PWR];
      case ({v[ddc_pkg::BIT_SEL_HI], v[ddc_pkg::BIT_SEL_LO]})
        ddc_pkg::SEL_B_BUF:
        begin
          eBuf = code;
          eB = code;
        end
        ddc_pkg::SEL_BUF: eBuf = code;
        ddc_pkg::SEL_A_XFER:
        begin
          eA = code;
          eB = eBuf;
        end
        default: eRef = v[1:0];
      endcase
      host_u.send_word(w, nbits);
      if (settle)
      begin
        repeat (12) @(negedge ref_clk);
        check();
      end
    end
  endtask : xfer

  initial
  begin
    arst_n = 1'b0;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    {eA, eB, eBuf, eSpd, ePwr, eRef} = '0;
    repeat (5) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    check();
    $display("test reset values done");

    // every reference code with all ignored bits set
    for (i = 0; i < 4; i++)
      xfer({4'hd, 10'h3ff, i[1:0]}, 16, 1'b1);
    // external reference chosen before one is applied
    xfer(16'hd000, 16, 1'b1);
    $display("test reference field done");

    xfer({4'h8, 10'h2a5, 2'h3}, 16, 1'b1);
    xfer({4'h1, 10'h1c3, 2'h0}, 16, 1'b1);
    xfer({4'hc, 10'h0f0, 2'h1}, 16, 1'b1);
    xfer({4'h4, 10'h355, 2'h2}, 16, 1'b1);
    $display("test targets done");

    xfer(16'hffff, 16, 1'b1);
    xfer({4'h3, 10'h0aa, 2'h0}, 16, 1'b1);
    xfer({4'h8, 10'h155, 2'h0}, 16, 1'b1);
    $display("test power down done");

    xfer(16'habc, 12, 1'b1);
    xfer({4'hd, 10'h000, 2'h1}, 16, 1'b1);
    $display("test short frame done");

    // back-to-back words, each applied before the next frame; only the last is settled and compared
    xfer({4'h1, 10'h011, 2'h0}, 16, 1'b0);
    xfer({4'hc, 10'h022, 2'h0}, 16, 1'b0);
    xfer({4'h4, 10'h033, 2'h0}, 16, 1'b0);
    xfer({4'h9, 10'h044, 2'h3}, 16, 1'b1);
    $display("test back to back done");
    conclude();
  end
endmodule : dual_dac_serial_command_decoder_tb

`undef CHK
`default_nettype wire
